// [rke_pkg.sv]
package rke_pkg;

  // ****************************************************************
  // Register offsets (byte addresses)
  // ****************************************************************
  localparam logic [7:0] ADDR_CARRIER    = 8'h00;
  localparam logic [7:0] ADDR_ENC0_RF    = 8'h04;
  localparam logic [7:0] ADDR_ENC1_RF    = 8'h08;
  localparam logic [7:0] ADDR_ENC0_TIME  = 8'h0c;
  localparam logic [7:0] ADDR_ENC1_TIME  = 8'h10;
  localparam logic [7:0] ADDR_ASSIGN     = 8'h14;
  localparam logic [7:0] ADDR_SEED       = 8'h18;
  localparam logic [7:0] ADDR_STATUS     = 8'h1c;

  // ****************************************************************
  // Field layouts
  // ****************************************************************
  localparam int CARRIER_W      = 19;
  localparam int DEV_LSB        = 0;
  localparam int DEV_W          = 16;
  localparam int BAND_BIT       = 16;
  localparam int POWER_BIT      = 17;
  localparam int MANCH_BIT      = 18;
  localparam int BLANK_LSB      = 20;
  localparam int TE_LSB         = 0;
  localparam int TE_W           = 16;
  localparam int MINW_LSB       = 16;
  localparam int MAXW_LSB       = 24;
  localparam int CNT_W          = 8;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [CARRIER_W-1:0] CARRIER_RST = 19'h40000;
  localparam logic [31:0] RF_RST     = 32'h0004_0000;
  localparam logic [31:0] TIME_RST   = 32'h0801_4e20;
  localparam logic [15:0] ASSIGN_RST = 16'h0000;
  localparam logic [15:0] SEED_RST   = 16'h0000;

  // ****************************************************************
  // Blanking modes
  // ****************************************************************
  localparam logic [1:0] BLANK_NONE = 2'h0;
  localparam logic [1:0] BLANK_HALF = 2'h1;

  // ****************************************************************
  // Code word lengths in time elements
  // ****************************************************************
  localparam logic [9:0] LEG_MANCH_TE = 10'd187;
  localparam logic [9:0] LEG_PWM_TE   = 10'd201;
  localparam logic [9:0] ENH_MANCH_TE = 10'd437;
  localparam logic [9:0] ENH_PWM_TE   = 10'd629;
  localparam int MANCH_TE_PER_BIT = 2;
  localparam int PWM_TE_PER_BIT   = 3;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int  CLK_HZ           = 200_000_000;
  localparam real LEG_OVH_MS       = 23.979;
  localparam real ENH_OVH_MS       = 46.527;
  localparam int  LEG_OVH_CYC      = int'($floor(LEG_OVH_MS * 200_000.0));
  localparam int  ENH_OVH_CYC      = int'($floor(ENH_OVH_MS * 200_000.0));
  localparam real LAMP_PERIOD_MS   = 100.0;
  localparam int  LAMP_PERIOD_CYC  = int'($floor(LAMP_PERIOD_MS * 200_000.0));
  localparam int  LAMP_ON_NORM_DIV = 2;
  localparam int  LAMP_ON_LOW_DIV  = 8;
  localparam logic [6:0] LOW_BATT_CODE = 7'd52;

  // ****************************************************************
  // Session states
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WORD = 3'b010,
    ST_HOLD = 3'b100
  } rke_state_type;

endpackage

// [rke_rf_rx.sv]
`timescale 1ns/1ps
`default_nettype none
// ********************
// Receiver side: measures each word slot
// ********************
module rke_rf_rx
  import rke_pkg::*;
(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             tx_active,
  input  wire logic             tx_radiate,
  input  wire logic             word_start,
  input  wire logic             tx_enhanced,
  input  wire logic             tx_seed,
  input  wire logic [DEV_W-1:0] deviation_word,
  input  wire logic             band_upper,
  input  wire logic             power_high,
  output logic                  got,
  output logic      [31:0]      got_len,
  output logic      [31:0]      got_rad,
  output logic      [19:0]      got_cfg
);
  logic [31:0] cnt;
  logic [31:0] rad;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= '0; rad <= '0; got <= 1'b0; got_len <= '0; got_rad <= '0; got_cfg <= '0;
    end else begin
      got <= 1'b0;
      if (cnt != 0 && (word_start || !tx_active)) begin
        got <= 1'b1; got_len <= cnt; got_rad <= rad;
      end
      if (word_start) begin
        cnt <= 32'd1; rad <= 32'(tx_radiate);
      end else if (tx_active) begin
        cnt <= cnt + 1; rad <= rad + 32'(tx_radiate);
        if (cnt == 1) got_cfg <= {tx_enhanced, tx_seed, band_upper, power_high, deviation_word};
      end else cnt <= '0;
    end
  end
endmodule // rke_rf_rx
`default_nettype wire

// [rke_tx_session_control.sv]
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// RL1: One shared carrier word for both encoders; deviation kept per encoder.
// RL2: Each encoder has its own band bit; 0 lower band, 1 upper band.
// RL3: Words scale by 2^14 in lower band, 2^13 in upper band.
// RL4: Software keeps carrier word and deviation inside the allowed range.
// RL5: Each encoder selects low or high output power, applied while it sends.
// RL6: Lamp pulses low during transmission, duty differs on low battery.
// RL7: Buttons form 4-bit index, button 0 least significant, selecting config bit.
// RL8: Index zero never starts a transmission; its config bit is ignored.
// RL9: Assignment bit clear picks legacy encoder, set picks enhanced encoder.
// RL10: Seed bit clear sends hopping word, set sends seed word.
// RL11: Config words stored as two bytes, lower byte holds bits 7 to 0.
// RL12: A started code word always runs to its end.
// RL13: After release, words continue until the minimum count is reached.
// RL14: Transmission stops at the per-encoder maximum word count.
// RL15: Manchester bit takes two time elements, pulse-width bit three.
// RL16: Legacy word lasts 187 or 201 elements plus fixed overhead.
// RL17: Enhanced word lasts 437 or 629 elements plus fixed overhead.
// RL18: Blank option radiates only one in two or one in four words.
// RL19: Low battery flag set when measured supply is below threshold; the code sets it when batt_level is above 52.
// RL20: Blanked slot keeps transmitter idle yet counts and times as sent.
module rke_tx_session_control
  import rke_pkg::*;
#(
  parameter int LEG_OVERHEAD_CYC = LEG_OVH_CYC,
  parameter int ENH_OVERHEAD_CYC = ENH_OVH_CYC,
  parameter int LAMP_PERIOD      = LAMP_PERIOD_CYC
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  input  wire logic [3:0]           pstrb,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 button_in_0,
  input  wire logic                 button_in_1,
  input  wire logic                 button_in_2,
  input  wire logic                 button_in_3,
  input  wire logic [6:0]           batt_level,
  output logic      [CARRIER_W-1:0] carrier_freq_word,
  output logic      [DEV_W-1:0]     deviation_word,
  output logic                      band_upper,
  output logic                      power_high,
  output logic                      tx_active,
  output logic                      tx_radiate,
  output logic                      tx_enhanced,
  output logic                      tx_seed,
  output logic                      word_start,
  output logic                      low_batt,
  output logic                      lamp_n
);

  // ****************************************************************
  // Code word duration in clock cycles
  // ****************************************************************
  function automatic logic [31:0] word_cycles(input logic enh, input logic manch,
                                              input logic [TE_W-1:0] te, input int legov,
                                              input int enhov);
    logic [9:0] elems;
    elems = enh ? (manch ? ENH_MANCH_TE : ENH_PWM_TE)                 // RL17 RL15
                : (manch ? LEG_MANCH_TE : LEG_PWM_TE);                // RL16 RL15
    word_cycles = 32'(elems * te) + (enh ? 32'(enhov) : 32'(legov));
  endfunction

  // ****************************************************************
  // Registers and state
  // ****************************************************************
  logic [CARRIER_W-1:0] carrier;
  logic [31:0]          rf_cfg [2];
  logic [31:0]          time_cfg [2];
  logic [15:0]          assign_word;
  logic [15:0]          seed_word;
  rke_state_type        state;
  logic                 enc;
  logic [CNT_W-1:0]     words_sent;
  logic [31:0]          word_left;
  logic [31:0]          lamp_cnt;

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  wire logic        acc      = psel & penable & pready;
  wire logic        wr       = acc & pwrite;
  wire logic        mapped   = (paddr[1:0] == 2'b00) && (paddr <= ADDR_STATUS);
  wire logic [31:0] wmask    = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
  wire logic        wr_car   = wr && paddr == ADDR_CARRIER;
  wire logic        wr_rf0   = wr && paddr == ADDR_ENC0_RF;
  wire logic        wr_rf1   = wr && paddr == ADDR_ENC1_RF;
  wire logic        wr_tm0   = wr && paddr == ADDR_ENC0_TIME;
  wire logic        wr_tm1   = wr && paddr == ADDR_ENC1_TIME;
  wire logic        wr_asg   = wr && paddr == ADDR_ASSIGN;
  wire logic        wr_seed  = wr && paddr == ADDR_SEED;

  // ****************************************************************
  // Button index and routing
  // ****************************************************************
  wire logic [3:0]  btn_idx   = {button_in_3, button_in_2, button_in_1, button_in_0}; // RL7
  wire logic        pressed   = btn_idx != 4'h0;                      // RL8
  wire logic        sel_enh   = assign_word[btn_idx];                 // RL7 RL9
  wire logic        sel_seed  = seed_word[btn_idx];                   // RL10
  wire logic        next_enc  = (state == ST_IDLE) ? sel_enh : enc;
  wire logic [31:0] cur_rf    = rf_cfg[next_enc];
  wire logic [31:0] cur_tm    = time_cfg[next_enc];
  wire logic [CNT_W-1:0] min_w = cur_tm[MINW_LSB +: CNT_W];
  wire logic [CNT_W-1:0] max_w = cur_tm[MAXW_LSB +: CNT_W];
  wire logic [TE_W-1:0]  te    = cur_tm[TE_LSB +: TE_W];
  wire logic [1:0]  blank     = cur_rf[BLANK_LSB +: 2];
  wire logic [31:0] next_len  = word_cycles(next_enc, cur_rf[MANCH_BIT], te,
                                            LEG_OVERHEAD_CYC, ENH_OVERHEAD_CYC);

  // ****************************************************************
  // Session sequencing
  // ****************************************************************
  wire logic [CNT_W-1:0] sent_inc = words_sent + 8'h01;
  wire logic        word_end  = (state == ST_WORD) && (word_left <= 32'h1); // RL12
  wire logic        at_max    = sent_inc >= max_w;                    // RL14
  wire logic        need_min  = sent_inc < min_w;                     // RL13
  wire logic        more      = !at_max && (pressed || need_min);
  wire logic        start_new = (state == ST_IDLE) && pressed;        // RL8
  wire logic        begin_w   = start_new || (word_end && more);
  wire logic [CNT_W-1:0] slot = start_new ? 8'h00 : sent_inc;
  wire logic        blanked   = (blank == BLANK_NONE) ? 1'b0 :        // RL18
                                (blank == BLANK_HALF) ? slot[0] : (slot[1:0] != 2'b00);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (pressed) begin
            state <= ST_WORD;
          end
        end
        ST_WORD: begin
          if (word_end && !more) begin
            state <= (at_max && pressed) ? ST_HOLD : ST_IDLE;         // RL14
          end
        end
        ST_HOLD: begin
          if (!pressed) begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enc        <= 1'b0;
      words_sent <= '0;
      word_left  <= '0;
      tx_enhanced <= 1'b0;
      tx_seed    <= 1'b0;
      tx_radiate <= 1'b0;
    end else if (begin_w) begin
      enc        <= next_enc;                                         // RL9
      words_sent <= slot;                                             // RL20
      word_left  <= next_len;                                         // RL20
      tx_enhanced <= next_enc;
      if (start_new) begin
        tx_seed  <= sel_seed;                                         // RL10
      end
      tx_radiate <= !blanked;                                         // RL18 RL20
    end else if (state == ST_WORD) begin
      word_left  <= word_left - 32'h1;
      if (word_end) begin
        tx_radiate <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_active  <= 1'b0;
      word_start <= 1'b0;
    end else begin
      tx_active  <= begin_w || (state == ST_WORD && !word_end);
      word_start <= begin_w;
    end
  end

  // ****************************************************************
  // Synthesizer settings
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      carrier_freq_word <= CARRIER_RST;
      deviation_word    <= RF_RST[DEV_LSB +: DEV_W];
      band_upper        <= RF_RST[BAND_BIT];
      power_high        <= RF_RST[POWER_BIT];
    end else begin
      carrier_freq_word <= carrier;                                   // RL1 RL3
      deviation_word    <= cur_rf[DEV_LSB +: DEV_W];                  // RL1 RL3
      band_upper        <= cur_rf[BAND_BIT];                          // RL2
      power_high        <= cur_rf[POWER_BIT];                         // RL5
    end
  end

  // ****************************************************************
  // Battery flag and lamp
  // ****************************************************************
  wire logic [31:0] lamp_on = low_batt ? 32'(LAMP_PERIOD / LAMP_ON_LOW_DIV)
                                       : 32'(LAMP_PERIOD / LAMP_ON_NORM_DIV);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_batt <= 1'b0;
      lamp_cnt <= '0;
      lamp_n   <= 1'b1;
    end else begin
      low_batt <= batt_level > LOW_BATT_CODE;                         // RL19
      if (!tx_active || lamp_cnt >= 32'(LAMP_PERIOD - 1)) begin
        lamp_cnt <= '0;
      end else begin
        lamp_cnt <= lamp_cnt + 32'h1;
      end
      lamp_n <= !(tx_active && lamp_cnt < lamp_on);                   // RL6
    end
  end

  // ****************************************************************
  // Register file
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      carrier     <= CARRIER_RST;
      rf_cfg[0]   <= RF_RST;
      rf_cfg[1]   <= RF_RST;
      time_cfg[0] <= TIME_RST;
      time_cfg[1] <= TIME_RST;
      assign_word <= ASSIGN_RST;
      seed_word   <= SEED_RST;
    end else begin
      if (wr_car) begin
        carrier <= (carrier & ~wmask[CARRIER_W-1:0]) | (pwdata[CARRIER_W-1:0] & wmask[CARRIER_W-1:0]);
      end
      if (wr_rf0) begin
        rf_cfg[0] <= (rf_cfg[0] & ~wmask) | (pwdata & wmask);
      end
      if (wr_rf1) begin
        rf_cfg[1] <= (rf_cfg[1] & ~wmask) | (pwdata & wmask);
      end
      if (wr_tm0) begin
        time_cfg[0] <= (time_cfg[0] & ~wmask) | (pwdata & wmask);
      end
      if (wr_tm1) begin
        time_cfg[1] <= (time_cfg[1] & ~wmask) | (pwdata & wmask);
      end
      if (wr_asg && pstrb[0]) begin
        assign_word[7:0] <= pwdata[7:0];                              // RL11
      end
      if (wr_asg && pstrb[1]) begin
        assign_word[15:8] <= pwdata[15:8];                            // RL11
      end
      if (wr_seed && pstrb[0]) begin
        seed_word[7:0] <= pwdata[7:0];                                // RL11
      end
      if (wr_seed && pstrb[1]) begin
        seed_word[15:8] <= pwdata[15:8];                              // RL11
      end
    end
  end

  // ****************************************************************
  // Read path, one wait state
  // ****************************************************************
  wire logic [31:0] status = {8'h00, words_sent, 8'h00, 1'b0, low_batt, tx_radiate,
                              tx_seed, enc, state};
  logic [31:0] rd_mux;
  always_comb begin
    case (paddr)
      ADDR_CARRIER:   rd_mux = {{(32-CARRIER_W){1'b0}}, carrier};
      ADDR_ENC0_RF:   rd_mux = rf_cfg[0];
      ADDR_ENC1_RF:   rd_mux = rf_cfg[1];
      ADDR_ENC0_TIME: rd_mux = time_cfg[0];
      ADDR_ENC1_TIME: rd_mux = time_cfg[1];
      ADDR_ASSIGN:    rd_mux = {16'h0000, assign_word};
      ADDR_SEED:      rd_mux = {16'h0000, seed_word};
      ADDR_STATUS:    rd_mux = status;
      default:        rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !mapped;
      if (psel && penable && !pready && !pwrite) begin
        prdata <= rd_mux;
      end
    end
  end

endmodule // rke_tx_session_control

`default_nettype wire

// [rke_tx_session_control_chk.sv]
`timescale 1ns/1ps
`default_nettype none
// ********************
// Session checker
// ********************
module rke_chk
  import rke_pkg::*;
(
  input wire logic                 pclk,
  input wire logic                 presetn,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [7:0]           paddr,
  input wire logic [31:0]          pwdata,
  input wire logic [3:0]           pstrb,
  input wire logic                 pready,
  input wire logic                 pslverr,
  input wire logic                 button_in_0,
  input wire logic                 button_in_1,
  input wire logic                 button_in_2,
  input wire logic                 button_in_3,
  input wire logic [6:0]           batt_level,
  input wire logic [CARRIER_W-1:0] carrier_freq_word,
  input wire logic                 tx_active,
  input wire logic                 tx_radiate,
  input wire logic                 tx_enhanced,
  input wire logic                 tx_seed,
  input wire logic                 word_start,
  input wire logic                 low_batt,
  input wire logic                 lamp_n
);
  wire [3:0] idx = {button_in_3, button_in_2, button_in_1, button_in_0};
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_idx_zero_idle: assert property (!tx_active && idx == 4'h0 |=> !word_start)
    else $error("word started with no button");
  a_start_pulse: assert property (word_start |=> !word_start)
    else $error("word start longer than one cycle");
  a_word_whole: assert property (word_start |-> tx_active ##1 tx_active [*8])
    else $error("word cut short");
  a_radiate_in_slot: assert property (tx_radiate |-> tx_active)
    else $error("radiating outside a slot");
  a_route_stable: assert property (tx_active && $past(tx_active) && !word_start
    |-> $stable(tx_enhanced) && $stable(tx_seed)) else $error("routing moved in a word");
  a_lamp_idle: assert property (!tx_active [*3] |-> lamp_n)
    else $error("lamp lit while idle");
  a_lamp_blink: assert property ($rose(tx_active) |-> ##[0:40] !lamp_n)
    else $error("lamp never lit");
  a_low_batt_flag: assert property ($past(presetn) |-> low_batt == ($past(batt_level) > 7'd52))
    else $error("low battery flag wrong");
  a_carrier_copy: assert property (psel && penable && pready && pwrite &&
    paddr == ADDR_CARRIER && pstrb == 4'hf |-> ##2
    carrier_freq_word == CARRIER_W'($past(pwdata, 2))) else $error("carrier not applied");
endmodule // rke_chk
bind rke_tx_session_control rke_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pstrb, .pready, .pslverr, .button_in_0, .button_in_1, .button_in_2, .button_in_3,
  .batt_level, .carrier_freq_word, .tx_active, .tx_radiate, .tx_enhanced, .tx_seed,
  .word_start, .low_batt, .lamp_n);
`default_nettype wire

// [rke_tx_session_control_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module rke_tx_session_control_tb
  import rke_pkg::*;
;
  typedef struct { logic [31:0] len; logic [31:0] rad; logic [19:0] cfg; } rke_exp_type;
  localparam int OVH = 50;
  localparam int LP  = 16;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, b0, b1, b2, b3;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rng, got_len, got_rad, carrier;
  logic [3:0] pstrb;
  logic [6:0] batt_level;
  logic [CARRIER_W-1:0] cfw;
  logic [DEV_W-1:0] dev_w;
  logic [31:0] rfw [2];
  logic [31:0] tmw [2];
  logic band, pow, act, rad, enh, sd, ws, lowb, lamp_n, got;
  logic [19:0] got_cfg;
  logic [15:0] assign_w, seed_w;
  int failures, compares, cycles, lit;
  rke_exp_type expq[$];
  rke_tx_session_control #(.LEG_OVERHEAD_CYC(OVH), .ENH_OVERHEAD_CYC(OVH), .LAMP_PERIOD(LP)) dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
    .pslverr, .button_in_0(b0), .button_in_1(b1), .button_in_2(b2), .button_in_3(b3),
    .batt_level, .carrier_freq_word(cfw), .deviation_word(dev_w), .band_upper(band),
    .power_high(pow), .tx_active(act), .tx_radiate(rad), .tx_enhanced(enh), .tx_seed(sd),
    .word_start(ws), .low_batt(lowb), .lamp_n);
  rke_rf_rx rx (.pclk, .presetn, .tx_active(act), .tx_radiate(rad), .word_start(ws),
    .tx_enhanced(enh), .tx_seed(sd), .deviation_word(dev_w), .band_upper(band),
    .power_high(pow), .got, .got_len, .got_rad, .got_cfg);
  // ********************
  // Shared tasks
  // ********************
  function automatic logic [31:0] rnd();
    rng ^= rng << 13; rng ^= rng >> 17; rng ^= rng << 5;
    return rng;
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] rd, output logic er);
    @(posedge pclk); psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
    @(posedge pclk); penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata; er = pslverr; psel <= 0; penable <= 0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic experr);
    logic [31:0] rd; logic er;
    apb(0, a, 0, 4'hf, rd, er);
    check("read data", rd, exp);
    check("read error", 32'(er), 32'(experr));
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] rd; logic er;
    apb(1, a, d, s, rd, er);
  endtask
  task automatic session(input logic [3:0] idx, input int hold);
    logic e; logic [1:0] bl; int n, ln, lp, tot, l0;
    e = assign_w[idx];
    bl = rfw[e][BLANK_LSB +: 2];
    ln = int'(e ? (rfw[e][MANCH_BIT] ? ENH_MANCH_TE : ENH_PWM_TE)
                : (rfw[e][MANCH_BIT] ? LEG_MANCH_TE : LEG_PWM_TE))
         * int'(tmw[e][TE_LSB +: TE_W]) + OVH;
    n = (hold > 1000) ? int'(tmw[e][MAXW_LSB +: CNT_W])
                      : int'(tmw[e][MINW_LSB +: CNT_W]);
    for (int k = 0; k < n; k++)
      expq.push_back('{32'(ln), (bl == BLANK_NONE || (bl == BLANK_HALF ? k % 2 == 0 : k % 4 == 0))
                       ? 32'(ln) : 32'd0,
                       {e, seed_w[idx], rfw[e][BAND_BIT], rfw[e][POWER_BIT],
                        rfw[e][DEV_W-1:0]}});
    l0 = lit;
    {b3, b2, b1, b0} <= idx;
    repeat (hold) @(posedge pclk);
    {b3, b2, b1, b0} <= 4'h0;
    do @(posedge pclk); while (act !== 1'b0 || expq.size() != 0);
    repeat (20) @(posedge pclk);
    tot = n * ln;
    lp = (batt_level > LOW_BATT_CODE) ? LP / LAMP_ON_LOW_DIV : LP / LAMP_ON_NORM_DIV;
    check("lamp lit cycles", 32'(lit - l0),
          32'((tot / LP) * lp + ((tot % LP < lp) ? tot % LP : lp)));
    check("low battery flag", 32'(lowb), 32'(batt_level > LOW_BATT_CODE));
    check("carrier word", 32'(cfw), carrier);
    $display("session %0d done", idx);
  endtask
  // ********************
  // Result watcher and stimulus
  // ********************
  always @(posedge pclk) begin
    rke_exp_type e;
    if (got === 1'b1) begin
      if (expq.size() == 0) check("spare word", 32'd1, 32'd0);
      else begin
        e = expq.pop_front();
        check("word length", got_len, e.len);
        check("radiated cycles", got_rad, e.rad);
        check("routing", 32'(got_cfg[19:18]), 32'(e.cfg[19:18]));
        check("rf settings", 32'(got_cfg[17:0]), 32'(e.cfg[17:0]));
      end
    end
  end
  always @(posedge pclk) begin
    cycles++;
    if (lamp_n === 1'b0) lit++;
    if (cycles == 40000) begin
      failures++;
      final_report();
    end
  end
  initial begin
    pclk = 0;
    forever #2.5 pclk = ~pclk;
  end
  initial begin
    presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = '0; pwdata = '0; pstrb = '0;
    {b3, b2, b1, b0} = 4'h0; batt_level = '0; rng = 32'd84902;
    failures = 0; compares = 0; cycles = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1;
    rdchk(ADDR_CARRIER, 32'(CARRIER_RST), 0);
    rdchk(ADDR_ENC1_RF, RF_RST, 0);
    rdchk(ADDR_ENC0_TIME, TIME_RST, 0);
    rdchk(ADDR_ASSIGN, 32'(ASSIGN_RST), 0);
    rdchk(8'h20, 32'h0, 1);
    rdchk(8'h06, 32'h0, 1);
    $display("reset and map test done");
    carrier = 32'd212993 + rnd() % 32'd131070;
    wr(ADDR_CARRIER, carrier, 4'hf);
    rdchk(ADDR_CARRIER, carrier, 0);
    rfw[0] = 32'h0004_0000 | 32'(16'd7 + 16'(rnd() % 32'd120));
    rfw[1] = 32'h0013_0000 | 32'(16'd4 + 16'(rnd() % 32'd60));
    tmw[0] = 32'h0302_0002;
    tmw[1] = 32'h0401_0001;
    wr(ADDR_ENC0_RF, rfw[0], 4'hf);
    wr(ADDR_ENC1_RF, rfw[1], 4'hf);
    wr(ADDR_ENC0_TIME, tmw[0], 4'hf);
    wr(ADDR_ENC1_TIME, tmw[1], 4'hf);
    assign_w = {8'haa, 8'(rnd()) | 8'h01};
    wr(ADDR_ASSIGN, 32'(assign_w), 4'hf);
    seed_w = 16'(rnd());
    wr(ADDR_SEED, 32'(seed_w), 4'hf);
    wr(ADDR_SEED, 32'hffff_ff5a, 4'b0001);
    seed_w[7:0] = 8'h5a;
    rdchk(ADDR_SEED, 32'(seed_w), 0);
    wr(ADDR_SEED, 32'hffff_c3ff, 4'b0010);
    seed_w[15:8] = 8'hc3;
    rdchk(ADDR_SEED, 32'(seed_w), 0);
    $display("config test done");
    batt_level <= 7'd52;
    session(4'd9, 5);
    batt_level <= 7'd53;
    session(4'd10, 3000);
    batt_level <= 7'(rnd());
    session(4'd11, 3000);
    session(4'(rnd() % 15 + 1), 5);
    rfw[0] = 32'h0022_0000 | 32'(16'd7 + 16'(rnd() % 32'd120));
    rfw[1] = 32'h0007_0000 | 32'(16'd4 + 16'(rnd() % 32'd60));
    wr(ADDR_ENC0_RF, rfw[0], 4'hf);
    wr(ADDR_ENC1_RF, rfw[1], 4'hf);
    session(4'd10, 3000);
    session(4'd11, 3000);
    final_report();
  end
endmodule // rke_tx_session_control_tb
`default_nettype wire
